// ---- design/pxs_pkg.sv ----
// package for the processor exception sequencer: constants, types, vectors
// What this block does
// [RULE_01] taking exception saves state, supervisor, fetches vector
// [RULE_02] conditions seen out of order, taken in order
// [RULE_03] older instructions and their exceptions go first
// [RULE_04] unmasked async seen at once, taken after drain
// [RULE_05] saved return address holds next instruction address
// [RULE_06] one exception at a time; reset, check preempt
// [RULE_07] several conditions of one instruction taken sequentially
// [RULE_08] recoverable imprecise fp mode behaves as precise
// [RULE_09] interrupt request input is maskable async exception
// [RULE_10] management and monitor interrupts maskable like external
// [RULE_11] maskable async waits for dispatched work to finish
// [RULE_12] external event enable gates all maskable async
// [RULE_13] reset and machine check nonmaskable, taken imprecisely
// [RULE_14] both fp mode bits clear: pipelined, no exceptions
// [RULE_15] low fp mode bit set: fp exception made precise
// [RULE_16] imprecise fp mode may save a later address
// [RULE_17] soft or hard reset vectors to 00100
// [RULE_18] qualified transfer error or check input: 00200
// [RULE_19] bus and cache parity errors raise machine check
// [RULE_20] check enable clear: machine check enters checkstop
// [RULE_21] taking any exception clears machine check enable
// [RULE_22] memory controller drives transfer error on faults
// [RULE_23] bus machine check imprecise to originating instruction
// [RULE_24] interrupt held till handler; vectors to 00500
// [RULE_25] state word copied to saved state before change
package pxs_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MSW_W  = 8;
    localparam int unsigned VEC_W  = 20;

    // register byte offsets
    localparam logic [7:0] REG_MSW    = 8'h00;
    localparam logic [7:0] REG_SRA    = 8'h04;
    localparam logic [7:0] REG_SMS    = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RETURN = 8'h10;

    // machine state word bit positions
    localparam int unsigned MSW_EE  = 0;
    localparam int unsigned MSW_PR  = 1;
    localparam int unsigned MSW_ME  = 2;
    localparam int unsigned MSW_FE0 = 3;
    localparam int unsigned MSW_FE1 = 4;
    localparam int unsigned MSW_IR  = 5;
    localparam int unsigned MSW_DR  = 6;

    localparam logic [7:0] MSW_RESET      = 8'h00;
    // bits kept on exception entry; all others cleared
    localparam logic [7:0] MSW_ENTRY_KEEP = 8'h00;

    localparam logic [19:0] VEC_RESERVED  = 20'h00000;
    localparam logic [19:0] VEC_SYS_RESET = 20'h00100;
    localparam logic [19:0] VEC_MCHECK    = 20'h00200;
    localparam logic [19:0] VEC_DSI       = 20'h00300;
    localparam logic [19:0] VEC_ISI       = 20'h00400;
    localparam logic [19:0] VEC_EXT       = 20'h00500;
    localparam logic [19:0] VEC_ALIGN     = 20'h00600;
    localparam logic [19:0] VEC_PROGRAM   = 20'h00700;
    localparam logic [19:0] VEC_FP        = 20'h00800;
    localparam logic [19:0] VEC_DECR      = 20'h00900;
    localparam logic [19:0] VEC_SMI       = 20'h00a00;
    localparam logic [19:0] VEC_PERF      = 20'h00b00;
    localparam logic [31:0] VEC_BASE      = 32'h00000000;

    typedef enum logic [3:0] {
        CAUSE_NONE    = 4'h0,
        CAUSE_RESET   = 4'h1,
        CAUSE_MCHECK  = 4'h2,
        CAUSE_DSI     = 4'h3,
        CAUSE_ISI     = 4'h4,
        CAUSE_EXT     = 4'h5,
        CAUSE_ALIGN   = 4'h6,
        CAUSE_PROGRAM = 4'h7,
        CAUSE_FP      = 4'h8,
        CAUSE_DECR    = 4'h9,
        CAUSE_SMI     = 4'ha,
        CAUSE_PERF    = 4'hb
    } pxs_cause_t;

    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_DRAIN     = 5'h02,
        ST_SAVE      = 5'h04,
        ST_VECTOR    = 5'h08,
        ST_CHECKSTOP = 5'h10
    } pxs_state_t;

    localparam int unsigned ASYNC_N = 4;
    // maskable sources, lowest index wins
    localparam pxs_cause_t ASYNC_CAUSE [ASYNC_N] =
        '{CAUSE_EXT, CAUSE_SMI, CAUSE_DECR, CAUSE_PERF};

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic        exc_valid;
        pxs_cause_t  exc_cause;
        logic        fp_exc;
    } pxs_retire_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pxs_bus_t;

    function automatic logic [19:0] pxs_vector(input pxs_cause_t c);
        case (c)
            CAUSE_RESET:   pxs_vector = VEC_SYS_RESET;
            CAUSE_MCHECK:  pxs_vector = VEC_MCHECK;
            CAUSE_DSI:     pxs_vector = VEC_DSI;
            CAUSE_ISI:     pxs_vector = VEC_ISI;
            CAUSE_EXT:     pxs_vector = VEC_EXT;
            CAUSE_ALIGN:   pxs_vector = VEC_ALIGN;
            CAUSE_PROGRAM: pxs_vector = VEC_PROGRAM;
            CAUSE_FP:      pxs_vector = VEC_FP;
            CAUSE_DECR:    pxs_vector = VEC_DECR;
            CAUSE_SMI:     pxs_vector = VEC_SMI;
            CAUSE_PERF:    pxs_vector = VEC_PERF;
            default:       pxs_vector = VEC_RESERVED;
        endcase
    endfunction

endpackage

// ---- design/pxs_async_select.sv ----
// priority selection among pending maskable asynchronous sources
`timescale 1ns/100ps
module pxs_async_select
    import pxs_pkg::*;
(
    input  wire logic [ASYNC_N-1:0] pending,
    input  wire logic               enable,
    output pxs_cause_t              cause,
    output logic                    valid
);

    logic [ASYNC_N-1:0] masked;
    logic [ASYNC_N-1:0] earlier;

    // one gate per source: a source wins if no lower index is pending
    genvar g;
    generate
        for (g = 0; g < ASYNC_N; g++) begin : gen_src
            assign masked[g] = pending[g] & enable; // RULE_12
            if (g == 0) begin : gen_first
                assign earlier[g] = 1'b0;
            end else begin : gen_rest
                assign earlier[g] = earlier[g-1] | masked[g-1];
            end
        end
    endgenerate

    always_comb begin
        cause = CAUSE_NONE;
        for (int i = 0; i < ASYNC_N; i++) begin
            if (masked[i] && !earlier[i]) begin
                cause = ASYNC_CAUSE[i];
            end
        end
    end

    assign valid = |masked;

endmodule // pxs_async_select

// ---- design/pxs_sequencer.sv ----
// exception recognition, ordering, state save and vectoring for the core
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module pxs_sequencer
    import pxs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire pxs_bus_t    bus,
    output logic [31:0]      rd_data,

    input  wire pxs_retire_t retire,
    input  wire logic        rob_empty,
    input  wire logic [31:0] next_fetch_pc,

    input  wire logic        ext_interrupt_req,
    input  wire logic        decrementer_req,
    input  wire logic        system_mgmt_interrupt_input,
    input  wire logic        perf_monitor_req,

    input  wire logic        soft_reset_req,
    input  wire logic        hard_reset_req,

    input  wire logic        machine_check_input,
    input  wire logic        bus_transfer_error,
    input  wire logic        bus_error_qualify,
    input  wire logic        addr_parity_error,
    input  wire logic        data_parity_error,
    input  wire logic        icache_parity_error,
    input  wire logic        dcache_parity_error,

    output logic             dispatch_hold,
    output logic             retire_hold,
    output logic             flush_pipeline,
    output logic             redirect_valid,
    output logic [31:0]      redirect_addr,
    output logic             supervisor_mode,
    output logic             checkstop,
    output logic             fpu_pipelined,
    output logic             fpu_precise
);

    pxs_state_t    state_reg;
    pxs_state_t    state_next;

    logic [7:0]    msw_reg;
    logic [31:0]   sra_reg;
    logic [7:0]    sms_reg;

    pxs_cause_t    pend_cause_reg;
    logic [31:0]   pend_ret_reg;

    pxs_cause_t    last_cause_reg;
    logic [31:0]   redirect_addr_reg;

    logic          return_pulse_reg;
    logic [31:0]   rd_data_reg;

    logic          async_seen_reg;

    logic [ASYNC_N-1:0] async_pending;
    pxs_cause_t    async_cause;
    logic          async_valid;

    logic          sys_reset_src;
    logic          mcheck_src;

    logic          fe0;
    logic          fe1;

    logic          instr_take;
    pxs_cause_t    instr_cause;
    logic [31:0]   instr_ret;

    logic          take_now;
    pxs_cause_t    take_cause;
    logic [31:0]   take_ret;

    logic          to_checkstop;
    logic          in_entry;
    logic          wr_return;

    assign fe0 = msw_reg[MSW_FE0];
    assign fe1 = msw_reg[MSW_FE1];

    // maskable sources in select order: external, management, decr, monitor
    assign async_pending = {perf_monitor_req,
                            decrementer_req,
                            system_mgmt_interrupt_input, // RULE_10
                            ext_interrupt_req};          // RULE_09 RULE_24

    pxs_async_select u_async_select (
        .pending (async_pending),
        .enable  (msw_reg[MSW_EE]),
        .cause   (async_cause),
        .valid   (async_valid)
    );

    assign sys_reset_src = soft_reset_req | hard_reset_req; // RULE_17

    assign mcheck_src = machine_check_input                 // RULE_18
                      | (bus_transfer_error & bus_error_qualify)
                      | addr_parity_error                   // RULE_19
                      | data_parity_error
                      | icache_parity_error
                      | dcache_parity_error;

    assign in_entry = (state_reg == ST_SAVE) || (state_reg == ST_VECTOR);

    // exceptions of the oldest retiring instruction only, so order holds
    always_comb begin
        instr_take  = 1'b0;
        instr_cause = CAUSE_NONE;
        instr_ret   = retire.pc;

        if (retire.valid && retire.exc_valid) begin // RULE_02 RULE_03
            // one cause per pass; rerun finds the next one
            instr_take  = 1'b1; // RULE_07
            instr_cause = retire.exc_cause;
            instr_ret   = retire.pc; // RULE_05
        end else if (retire.valid && retire.fp_exc) begin
            if (fe0) begin
                // precise, also for the recoverable imprecise request
                instr_take  = 1'b1; // RULE_15 RULE_08
                instr_cause = CAUSE_FP;
                instr_ret   = retire.pc;
            end else if (fe1) begin
                // imprecise nonrecoverable: resume after the faulting one
                instr_take  = 1'b1;
                instr_cause = CAUSE_FP;
                instr_ret   = retire.next_pc; // RULE_16
            end
            // both bits clear: the fpu already returned a default result
        end
    end

    // decide what, if anything, is taken this cycle
    always_comb begin
        take_now     = 1'b0;
        take_cause   = CAUSE_NONE;
        take_ret     = next_fetch_pc;
        to_checkstop = 1'b0;

        if (sys_reset_src) begin
            // preempts anything, including an entry in progress
            take_now   = 1'b1; // RULE_06 RULE_13
            take_cause = CAUSE_RESET;
        end else if (state_reg == ST_CHECKSTOP) begin
            take_now = 1'b0;
        end else if (mcheck_src) begin
            // imprecise: no wait for the instruction behind the bus cycle
            if (msw_reg[MSW_ME]) begin
                take_now   = 1'b1; // RULE_13 RULE_23
                take_cause = CAUSE_MCHECK;
            end else begin
                to_checkstop = 1'b1; // RULE_20
            end
        end else if (!in_entry && instr_take) begin
            take_now   = 1'b1; // RULE_03
            take_cause = instr_cause;
            take_ret   = instr_ret;
        end else if (state_reg == ST_DRAIN && rob_empty && !retire.valid
                     && async_valid) begin
            take_now   = 1'b1; // RULE_04 RULE_11
            take_cause = async_cause;
            take_ret   = next_fetch_pc; // RULE_05
        end
    end

    always_comb begin
        state_next = state_reg;

        case (state_reg)
            ST_IDLE: begin
                if (async_valid) begin
                    state_next = ST_DRAIN; // RULE_04
                end
            end

            ST_DRAIN: begin
                if (!async_valid) begin
                    state_next = ST_IDLE;
                end
            end

            ST_SAVE: begin
                state_next = ST_VECTOR;
            end

            ST_VECTOR: begin
                state_next = ST_IDLE;
            end

            ST_CHECKSTOP: begin
                state_next = ST_CHECKSTOP;
            end

            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // checkstop and exception entry override the step above
        if (to_checkstop) begin
            state_next = ST_CHECKSTOP;
        end else if (take_now) begin
            state_next = ST_SAVE;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // cause and return address latched when the exception is taken
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pend_cause_reg <= CAUSE_NONE;
            pend_ret_reg   <= 32'h00000000;
        end else if (take_now && !to_checkstop) begin
            pend_cause_reg <= take_cause;
            pend_ret_reg   <= take_ret;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            async_seen_reg <= 1'b0;
        end else if (state_reg == ST_SAVE) begin
            async_seen_reg <= 1'b0;
        end else if (async_valid) begin
            async_seen_reg <= 1'b1; // RULE_04
        end
    end

    assign wr_return = bus.wr && (bus.addr == REG_RETURN)
                     && (state_reg == ST_IDLE) && !take_now;

    // machine state word: save wins over software writes
    always_ff @(posedge clock) begin
        if (!nrst) begin
            msw_reg <= MSW_RESET;
        end else if (state_reg == ST_SAVE) begin
            // supervisor, interrupts off, check enable cleared
            msw_reg <= msw_reg & MSW_ENTRY_KEEP; // RULE_01 RULE_21
        end else if (wr_return) begin
            msw_reg <= sms_reg;
        end else if (bus.wr && bus.addr == REG_MSW) begin
            msw_reg <= bus.wdata[MSW_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sms_reg <= MSW_RESET;
        end else if (state_reg == ST_SAVE) begin
            // old word captured on the same edge it is changed
            sms_reg <= msw_reg; // RULE_25
        end else if (bus.wr && bus.addr == REG_SMS) begin
            sms_reg <= bus.wdata[MSW_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sra_reg <= 32'h00000000;
        end else if (state_reg == ST_SAVE) begin
            sra_reg <= pend_ret_reg; // RULE_01 RULE_05
        end else if (bus.wr && bus.addr == REG_SRA) begin
            sra_reg <= bus.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            last_cause_reg <= CAUSE_NONE;
        end else if (state_reg == ST_SAVE) begin
            last_cause_reg <= pend_cause_reg;
        end
    end

    // fetch redirect: exception vector or return to the saved address
    always_ff @(posedge clock) begin
        if (!nrst) begin
            redirect_addr_reg <= 32'h00000000;
        end else if (state_reg == ST_SAVE) begin
            redirect_addr_reg <= VEC_BASE
                | {12'h000, pxs_vector(pend_cause_reg)}; // RULE_01
        end else if (wr_return) begin
            redirect_addr_reg <= sra_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            return_pulse_reg <= 1'b0;
        end else begin
            return_pulse_reg <= wr_return;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_data_reg <= 32'h00000000;
        end else if (bus.rd) begin
            case (bus.addr)
                REG_MSW:    rd_data_reg <= {24'h000000, msw_reg};
                REG_SRA:    rd_data_reg <= sra_reg;
                REG_SMS:    rd_data_reg <= {24'h000000, sms_reg};
                REG_STATUS: rd_data_reg <= {16'h0000,
                                            3'h0, state_reg,
                                            async_seen_reg,
                                            mcheck_src,
                                            async_valid,
                                            1'b0,
                                            last_cause_reg};
                default:    rd_data_reg <= 32'h00000000;
            endcase
        end else begin
            rd_data_reg <= 32'h00000000;
        end
    end

    assign rd_data         = rd_data_reg;

    // no new dispatch while draining or entering
    assign dispatch_hold   = (state_reg != ST_IDLE) || async_valid; // RULE_11
    assign retire_hold     = in_entry || (state_reg == ST_CHECKSTOP);

    assign flush_pipeline  = (state_reg == ST_SAVE);
    assign redirect_valid  = (state_reg == ST_VECTOR) || return_pulse_reg;
    assign redirect_addr   = redirect_addr_reg;

    assign supervisor_mode = !msw_reg[MSW_PR]; // RULE_01
    assign checkstop       = (state_reg == ST_CHECKSTOP);
    assign fpu_pipelined   = !fe0 && !fe1; // RULE_14
    assign fpu_precise     = fe0; // RULE_15 RULE_08

endmodule // pxs_sequencer

// ---- bench/pxs_seq_asserts.sv ----
// assertions on the exception sequencer ports
`timescale 1ns/100ps
module pxs_seq_asserts
    import pxs_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire pxs_retire_t retire,
    input wire logic        rob_empty,
    input wire logic        soft_reset_req,
    input wire logic        hard_reset_req,
    input wire logic        machine_check_input,
    input wire logic        bus_transfer_error,
    input wire logic        bus_error_qualify,
    input wire logic        dispatch_hold,
    input wire logic        retire_hold,
    input wire logic        flush_pipeline,
    input wire logic        redirect_valid,
    input wire logic [31:0] redirect_addr,
    input wire logic        supervisor_mode,
    input wire logic        checkstop,
    input wire logic        fpu_pipelined,
    input wire logic        fpu_precise
);
    localparam logic [31:0] RST_A = VEC_BASE | {12'h0, VEC_SYS_RESET};
    localparam logic [31:0] MC_A  = VEC_BASE | {12'h0, VEC_MCHECK};
    localparam logic [31:0] EXT_A = VEC_BASE | {12'h0, VEC_EXT};
    logic rq;
    logic mc;
    assign rq = soft_reset_req | hard_reset_req;
    assign mc = machine_check_input | (bus_transfer_error & bus_error_qualify);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    flush_then_jump_a: assert property (flush_pipeline && !rq && !mc
        |=> redirect_valid && supervisor_mode) else $error("no vector jump");
    flush_single_a: assert property (flush_pipeline && !rq && !mc
        |=> !flush_pipeline) else $error("flush longer than one cycle");
    hold_dispatch_a: assert property (retire_hold |-> dispatch_hold)
        else $error("dispatch not held during entry");
    fp_precise_a: assert property (fpu_precise |-> !fpu_pipelined)
        else $error("precise fp mode left pipelined");
    stop_stays_a: assert property (checkstop && !rq |=> checkstop)
        else $error("checkstop left without reset");
    reset_vector_a: assert property (rq ##1 !rq && !mc
        |=> redirect_valid && redirect_addr == RST_A)
        else $error("reset vector wrong");
    check_vector_a: assert property (mc ##1 !mc && !rq
        |=> (redirect_valid && redirect_addr == MC_A) || checkstop)
        else $error("machine check vector wrong");
    drain_first_a: assert property (redirect_valid &&
        redirect_addr == EXT_A && $past(flush_pipeline)
        |-> $past(rob_empty, 2) && !$past(retire.valid, 2))
        else $error("interrupt taken before drain");
endmodule // pxs_seq_asserts

bind pxs_sequencer pxs_seq_asserts chk (.clock, .nrst, .retire, .rob_empty,
    .soft_reset_req, .hard_reset_req, .machine_check_input,
    .bus_transfer_error, .bus_error_qualify, .dispatch_hold, .retire_hold,
    .flush_pipeline, .redirect_valid, .redirect_addr, .supervisor_mode,
    .checkstop, .fpu_pipelined, .fpu_precise);

// ---- bench/pxs_far_side.sv ----
// far side model: interrupt source and memory controller
`timescale 1ns/100ps
module pxs_far_side
    import pxs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [3:0] raise,
    input  wire logic       drop,
    input  wire logic       fault,
    input  wire logic       redirect_valid,
    output logic [3:0]      irq,
    output logic            bus_transfer_error,
    output logic            bus_error_qualify
);
    // requests stay up until drop is raised or the next redirect (handler entry or return)
    always_ff @(posedge clock) begin
        if (!nrst || drop || redirect_valid) begin
            irq <= 4'h0;
        end else begin
            irq <= irq | raise;
        end
    end
    // a failed load or store reports one qualified error cycle
    always_ff @(posedge clock) begin
        bus_transfer_error <= nrst && fault;
        bus_error_qualify  <= nrst && fault;
    end
endmodule // pxs_far_side

// ---- bench/processor_exception_sequencer_test.sv ----
// self-checking bench for the exception sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value at %0t: got %h expected %h", \
    $time, (g), (e)); end end
module processor_exception_sequencer_test;
    import pxs_pkg::*;
    logic        clock, nrst, rob_empty, drop;
    logic [7:0]  src, m;
    logic [3:0]  raise, irq;
    logic [31:0] next_fetch_pc, rd_data, redirect_addr, got, pc, npc, ret;
    pxs_bus_t    bus;
    pxs_retire_t retire;
    logic        bus_transfer_error, bus_error_qualify, dispatch_hold;
    logic        retire_hold, flush_pipeline, redirect_valid;
    logic        supervisor_mode, checkstop, fpu_pipelined, fpu_precise;
    int          err_count, samples_checked;
    localparam logic [7:0] MS [5] = '{8'h05, 8'h0c, 8'h1c, 8'h14, 8'h04};

    pxs_sequencer dut (
        .clock, .nrst, .bus, .rd_data, .retire, .rob_empty, .next_fetch_pc,
        .ext_interrupt_req(irq[0]), .system_mgmt_interrupt_input(irq[1]),
        .decrementer_req(irq[2]), .perf_monitor_req(irq[3]),
        .soft_reset_req(src[0]), .hard_reset_req(src[1]),
        .machine_check_input(src[2]), .addr_parity_error(src[3]),
        .data_parity_error(src[4]), .icache_parity_error(src[5]),
        .dcache_parity_error(src[6]), .bus_transfer_error,
        .bus_error_qualify, .dispatch_hold, .retire_hold, .flush_pipeline,
        .redirect_valid, .redirect_addr, .supervisor_mode, .checkstop,
        .fpu_pipelined, .fpu_precise);
    pxs_far_side far (.clock, .nrst, .raise, .drop, .fault(src[7]),
        .redirect_valid, .irq, .bus_transfer_error, .bus_error_qualify);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] va(input logic [19:0] v);
        return VEC_BASE | {12'h0, v};
    endfunction
    function automatic logic [19:0] av(input int i);
        case (i)
            0: return VEC_EXT;
            1: return VEC_SMI;
            2: return VEC_DECR;
            default: return VEC_PERF;
        endcase
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 q = rd_data;
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        src[k] <= 1'b1;
        @(posedge clock);
        src[k] <= 1'b0;
    endtask
    task automatic wait_jump(output logic [31:0] a);
        for (int i = 0; i < 40; i++) begin
            #1;
            if (redirect_valid === 1'b1) begin
                a = redirect_addr;
                return;
            end
            @(posedge clock);
        end
        err_count++;
        $display("timeout waiting for a jump at %0t", $time);
        final_report();
    endtask

    initial begin
        bus = '0; retire = '0; rob_empty = 1'b1; next_fetch_pc = 32'h0;
        src = 8'h0; raise = 4'h0; drop = 1'b0; nrst = 1'b0;
        err_count = 0; samples_checked = 0;
        void'($urandom(62120));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1 `CHK({supervisor_mode, checkstop, fpu_pipelined}, 3'b101)
        pulse(2);
        repeat (2) @(posedge clock);
        #1 `CHK(checkstop, 1'b1)
        for (int k = 0; k < 2; k++) begin
            pulse(k);
            wait_jump(got);
            `CHK(got, va(VEC_SYS_RESET))
            `CHK(checkstop, 1'b0)
        end
        $display("test resets done");
        for (int i = 0; i < 8; i++) begin
            m = 8'($urandom) & 8'h1f;
            wr(REG_MSW, {24'h0, m});
            rd(REG_MSW, got);
            `CHK(got, {24'h0, m})
            `CHK({fpu_pipelined, fpu_precise}, {!m[3] && !m[4], m[3]})
            `CHK(supervisor_mode, !m[1])
        end
        $display("test fp modes done");
        for (int k = 2; k < 8; k++) begin
            wr(REG_MSW, 32'h4);
            pulse(k);
            wait_jump(got);
            `CHK(got, va(VEC_MCHECK))
            rd(REG_MSW, got);
            `CHK(got, 32'h0)
        end
        $display("test machine checks done");
        for (int i = 0; i < 4; i++) begin
            wr(REG_MSW, 32'h5);
            next_fetch_pc <= $urandom;
            rob_empty <= 1'b0;
            raise <= 4'(1 << i);
            @(posedge clock);
            raise <= 4'h0;
            repeat (6) @(posedge clock);
            #1 `CHK({dispatch_hold, redirect_valid}, 2'b10)
            @(posedge clock);
            rob_empty <= 1'b1;
            wait_jump(got);
            `CHK(got, va(av(i)))
            `CHK(supervisor_mode, 1'b1)
            rd(REG_SRA, got);
            `CHK(got, next_fetch_pc)
            rd(REG_SMS, got);
            `CHK(got, 32'h5)
        end
        wr(REG_MSW, 32'h4);
        raise <= 4'h1;
        @(posedge clock);
        raise <= 4'h0;
        repeat (4) @(posedge clock);
        #1 `CHK(dispatch_hold, 1'b0)
        @(posedge clock);
        drop <= 1'b1;
        @(posedge clock);
        drop <= 1'b0;
        $display("test interrupts done");
        for (int j = 0; j < 5; j++) begin
            wr(REG_MSW, {24'h0, MS[j]});
            pc = $urandom;
            npc = $urandom;
            rob_empty <= (j != 0);
            raise <= {3'h0, j == 0};
            @(posedge clock);
            raise <= 4'h0;
            @(posedge clock);
            retire <= '{valid: 1'b1, pc: pc, next_pc: npc, exc_valid: j == 0,
                exc_cause: (j == 0) ? CAUSE_PROGRAM : CAUSE_FP,
                fp_exc: (j != 0)};
            @(posedge clock);
            retire <= '0;
            rob_empty <= 1'b1;
            if (j == 4) begin
                rd(REG_MSW, got);
                `CHK(got, 32'h4)
            end else begin
                wait_jump(got);
                `CHK(got, va(j == 0 ? VEC_PROGRAM : VEC_FP))
                rd(REG_SRA, got);
                `CHK(got, (j == 3) ? npc : pc)
                if (j == 3) ret = npc;
            end
        end
        wr(REG_RETURN, 32'h0);
        wait_jump(got);
        `CHK(got, ret)
        rd(REG_MSW, got);
        `CHK(got, {24'h0, MS[3]})
        $display("test ordering done");
        final_report();
    end
endmodule // processor_exception_sequencer_test
